// >>> scir_pkg.sv
/*
 * Constants for the configuration and identification register bank.
 * Assumes byte-wide registers on a 15-bit address space behind the SPI register port.
 */
// Summary of operation
// R1 - Writing one to interface config bit 7 resets the chip and all registers.
// R2 - The chip reset bit clears itself and always reads back zero.
// R3 - Host starts no SPI transaction until the 5 ns reset interval has passed.
// R4 - Streaming address decrements when direction bit 5 is zero, increments when one.
// R5 - Power mode bits 1-0: 0 normal, 3 full power down, 1-2 reserved; reset 0.
// R6 - Device class bits 3-0 read a fixed code; upper four bits reset to zero.
// R7 - Sixteen-bit family identifier always reads the same fixed code.
// R8 - Writes to identification fields are ignored and later reads stay fixed.
package scir_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Register offsets
	localparam logic [14:0] OFS_INTERFACE_CONFIG = 15'h0000;
	localparam logic [14:0] OFS_POWER_MODE_CONFIG = 15'h0002;
	localparam logic [14:0] OFS_DEVICE_CLASS_CODE = 15'h0003;
	localparam logic [14:0] OFS_FAMILY_ID_LO = 15'h0004;
	localparam logic [14:0] OFS_FAMILY_ID_HI = 15'h0005;
	localparam logic [14:0] OFS_SILICON_REVISION = 15'h0006;
	localparam logic [14:0] OFS_MAKER_ID_LO = 15'h000C;
	localparam logic [14:0] OFS_MAKER_ID_HI = 15'h000D;
	localparam logic [14:0] OFS_SYNC_REFERENCE_CONTROL = 15'h0080;

	////////////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [7:0] RST_INTERFACE_CONFIG = 8'h30;
	localparam logic [7:0] RST_POWER_MODE_CONFIG = 8'h00;
	localparam logic [3:0] RST_CLASS_UPPER = 4'h0;
	localparam logic [7:0] RST_SYNC_REFERENCE_CONTROL = 8'h40;

	////////////////////////////////////////////////////////////////////////////////
	// Field positions and encodings
	localparam int BIT_CHIP_RESET = 7;
	localparam int BIT_ADDRESS_DIRECTION_UP = 5;
	localparam int BIT_FIXED_ONE = 4;
	localparam logic [1:0] MODE_NORMAL = 2'h0;
	localparam logic [1:0] MODE_FULL_POWER_DOWN = 2'h3;

	////////////////////////////////////////////////////////////////////////////////
	// Frame layout: read flag plus 15 address bits, then whole data bytes
	localparam logic [4:0] HEADER_LAST_BIT = 5'h0F;
	localparam logic [4:0] BYTE_LAST_BIT = 5'h07;

	////////////////////////////////////////////////////////////////////////////////
	// Chip reset interval, a longest time, so it rounds down with a floor of one
	localparam int CLK_PERIOD_NS = 10;
	localparam int CHIP_RESET_TIME_NS = 5;
	localparam int CHIP_RESET_CYCLES_RAW = CHIP_RESET_TIME_NS / CLK_PERIOD_NS;
	localparam logic [3:0] CHIP_RESET_CYCLES =
		(CHIP_RESET_CYCLES_RAW < 1) ? 4'h1 : 4'(CHIP_RESET_CYCLES_RAW);

	////////////////////////////////////////////////////////////////////////////////
	// Frame phase
	typedef enum logic [0:0] {PH_HEADER, PH_DATA} scir_phase_e;

endpackage

// >>> scir_pin_sync.sv
/*
 * Three-stage pin synchroniser with agreement filter.
 * Assumes asynchronous pins; output changes only when stages two and three agree.
 */
`timescale 1ns/1ns
module scir_pin_sync #(
	parameter int WIDTH = 3,
	parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Pins and filtered levels
	input wire logic [WIDTH-1:0] pin_async,
	output logic [WIDTH-1:0] pin_stable
);

	typedef struct packed {
		logic [WIDTH-1:0] stage1;
		logic [WIDTH-1:0] stage2;
		logic [WIDTH-1:0] stage3;
		logic [WIDTH-1:0] stable;
	} scir_sync_s;

	scir_sync_s st;
	scir_sync_s next_st;

	////////////////////////////////////////////////////////////////////////////////
	// Shift chain and agreement update
	always_comb begin
		next_st = st;
		next_st.stage1 = pin_async;
		next_st.stage2 = st.stage1;
		next_st.stage3 = st.stage2;
		for (int i = 0; i < WIDTH; i++) begin
			if (st.stage2[i] == st.stage3[i]) begin
				next_st.stable[i] = st.stage3[i];
			end
		end
	end

	// Stage register, pins reset to their idle levels
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			st <= {RESET_VALUE, RESET_VALUE, RESET_VALUE, RESET_VALUE};
		end else begin
			st <= next_st;
		end
	end

	assign pin_stable = st.stable;

endmodule

// >>> scir_regs.sv
/*
 * SPI register port with configuration and identification registers.
 * A frame is a read flag, 15 address bits and whole data bytes, MSB first;
 * each complete byte written to a writable offset is stored, and after any byte the address steps for streaming.
 * A soft reset write reloads every register and sends the parser back to
 * the header, so the host must end that frame. Partial bytes are dropped.
 * Assumes SPI mode 0 from a host on pins, with sclk slow against sys_clk
 * (each sclk level held at least 8 sys_clk cycles).
 */
`timescale 1ns/1ns
module scir_regs #(
	parameter logic [3:0] DEVICE_CLASS = 4'hA,      // Arbitrary value
	parameter logic [15:0] FAMILY_CODE = 16'h1234,  // Arbitrary value
	parameter logic [7:0] REVISION_CODE = 8'h01,    // Arbitrary value
	parameter logic [15:0] MAKER_CODE = 16'h5A5A    // Arbitrary value
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// SPI register port pins
	input wire logic spi_sclk,
	input wire logic spi_cs_n,
	input wire logic spi_sdi,
	output logic spi_sdo,
	output logic spi_sdo_oe,
	// Controls to the rest of the chip
	output logic chip_reset_request,
	output logic address_direction_up,
	output logic [1:0] power_mode,
	output logic full_power_down,
	output logic [7:0] sync_reference_control
);

	// Whole block state, held in one register
	typedef struct packed {
		logic sclk_prev;
		scir_pkg::scir_phase_e phase;
		logic [4:0] bit_cnt;
		logic [15:0] shift;
		logic is_read;
		logic [14:0] addr;
		logic [7:0] read_shift;
		logic sdo;
		logic sdo_oe;
		logic [3:0] reset_cnt;
		logic reset_out;
		logic [7:0] interface_config;
		logic [7:0] power_mode_config;
		logic [3:0] class_upper;
		logic [7:0] sync_ctrl;
		logic power_down;
	} scir_regs_s;

	scir_regs_s st;
	scir_regs_s next_st;
	// Filtered pin levels and the bytes in flight
	logic [2:0] pins_stable;
	logic sclk_f;
	logic cs_n_f;
	logic sdi_f;
	logic [7:0] wr_byte;
	logic [7:0] rd_byte;

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers, chip select idles high
	scir_pin_sync #(
		.WIDTH(3),
		.RESET_VALUE(3'h2)
	) u_pin_sync (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.pin_async({spi_sdi, spi_cs_n, spi_sclk}),
		.pin_stable(pins_stable)
	);

	assign sclk_f = pins_stable[0];
	assign cs_n_f = pins_stable[1];
	assign sdi_f = pins_stable[2];
	assign wr_byte = {st.shift[6:0], sdi_f};

	////////////////////////////////////////////////////////////////////////////////
	// Next streaming address
	function automatic logic [14:0] step_addr(input logic [14:0] a, input logic up);
		// Wraps within the 15-bit address space
		step_addr = up ? 15'(a + 15'h0001) : 15'(a - 15'h0001); // [R4]
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Read decode; unmapped offsets read zero
	function automatic logic [7:0] read_reg(input logic [14:0] a, input scir_regs_s s);
		logic [7:0] v;
		v = 8'h00;
		case (a)
			scir_pkg::OFS_INTERFACE_CONFIG: begin
				v = s.interface_config;
				v[scir_pkg::BIT_CHIP_RESET] = 1'b0; // [R2]
				v[scir_pkg::BIT_FIXED_ONE] = 1'b1;
			end
			scir_pkg::OFS_POWER_MODE_CONFIG: v = s.power_mode_config;
			scir_pkg::OFS_DEVICE_CLASS_CODE: v = {s.class_upper, DEVICE_CLASS}; // [R6]
			// Identification codes are fixed parameters; no write reaches them
			scir_pkg::OFS_FAMILY_ID_LO: v = FAMILY_CODE[7:0]; // [R7]
			scir_pkg::OFS_FAMILY_ID_HI: v = FAMILY_CODE[15:8]; // [R7]
			scir_pkg::OFS_SILICON_REVISION: v = REVISION_CODE;
			scir_pkg::OFS_MAKER_ID_LO: v = MAKER_CODE[7:0];
			scir_pkg::OFS_MAKER_ID_HI: v = MAKER_CODE[15:8];
			scir_pkg::OFS_SYNC_REFERENCE_CONTROL: v = s.sync_ctrl;
			default: v = 8'h00;
		endcase
		read_reg = v;
	endfunction

	// Byte at the current address, loaded into the read shifter at a byte start
	assign rd_byte = read_reg(st.addr, st);

	////////////////////////////////////////////////////////////////////////////////
	// Frame decode, register writes and chip reset
	always_comb begin
		next_st = st;
		next_st.sclk_prev = sclk_f;
		// Chip reset request stays out for the reset interval
		if (st.reset_cnt != 4'h0) begin
			next_st.reset_cnt = 4'(st.reset_cnt - 4'h1);
		end
		next_st.reset_out = (next_st.reset_cnt != 4'h0);
		// Chip select high: parser idle, data pin released
		if (cs_n_f) begin
			next_st.phase = scir_pkg::PH_HEADER;
			next_st.bit_cnt = 5'h00;
			next_st.sdo_oe = 1'b0;
			next_st.sdo = 1'b0;
		end else if (sclk_f && !st.sclk_prev) begin
			// Rising edge: sample one bit
			next_st.shift = {st.shift[14:0], sdi_f};
			next_st.bit_cnt = 5'(st.bit_cnt + 5'h01);
			case (st.phase)
				scir_pkg::PH_HEADER: begin
					if (st.bit_cnt == scir_pkg::HEADER_LAST_BIT) begin
						next_st.is_read = st.shift[14];
						next_st.addr = {st.shift[13:0], sdi_f};
						next_st.phase = scir_pkg::PH_DATA;
						next_st.bit_cnt = 5'h00;
					end
				end
				scir_pkg::PH_DATA: begin
					if (st.bit_cnt == scir_pkg::BYTE_LAST_BIT) begin
						next_st.bit_cnt = 5'h00;
						next_st.addr = step_addr(st.addr, st.interface_config[scir_pkg::BIT_ADDRESS_DIRECTION_UP]); // [R4]
						if (!st.is_read) begin
							// Whole byte written: store it at the byte's own address
							case (st.addr)
								scir_pkg::OFS_INTERFACE_CONFIG: begin
									if (wr_byte[scir_pkg::BIT_CHIP_RESET]) begin
										// Whole bank back to defaults, frame restarts
										next_st.interface_config = scir_pkg::RST_INTERFACE_CONFIG; // [R1]
										next_st.power_mode_config = scir_pkg::RST_POWER_MODE_CONFIG; // [R1]
										next_st.class_upper = scir_pkg::RST_CLASS_UPPER; // [R1]
										next_st.sync_ctrl = scir_pkg::RST_SYNC_REFERENCE_CONTROL; // [R1]
										next_st.reset_cnt = scir_pkg::CHIP_RESET_CYCLES; // [R1]
										next_st.reset_out = 1'b1; // [R1]
										next_st.phase = scir_pkg::PH_HEADER; // [R3]
									end else begin
										next_st.interface_config = wr_byte;
										next_st.interface_config[scir_pkg::BIT_FIXED_ONE] = 1'b1;
									end
									next_st.interface_config[scir_pkg::BIT_CHIP_RESET] = 1'b0; // [R2]
								end
								scir_pkg::OFS_POWER_MODE_CONFIG: next_st.power_mode_config = wr_byte; // [R5]
								scir_pkg::OFS_DEVICE_CLASS_CODE: next_st.class_upper = wr_byte[7:4]; // [R6] [R8]
								scir_pkg::OFS_SYNC_REFERENCE_CONTROL: next_st.sync_ctrl = wr_byte;
								default: begin // [R8]
									// Read-only and unmapped offsets: byte dropped, no side effect
								end
							endcase
						end
					end
				end
				default: next_st.phase = scir_pkg::PH_HEADER;
			endcase
		end else if (!sclk_f && st.sclk_prev) begin
			// Falling edge: present the next read bit
			if (st.phase == scir_pkg::PH_DATA && st.is_read) begin
				next_st.sdo_oe = 1'b1;
				if (st.bit_cnt == 5'h00) begin
					next_st.sdo = rd_byte[7];
					next_st.read_shift = {rd_byte[6:0], 1'b0};
				end else begin
					next_st.sdo = st.read_shift[7];
					next_st.read_shift = {st.read_shift[6:0], 1'b0};
				end
			end
		end
		// Power-down flag follows the stored mode, registered with it
		next_st.power_down = (next_st.power_mode_config[1:0] == scir_pkg::MODE_FULL_POWER_DOWN); // [R5]
	end

	// State register; reset loads the register defaults
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			st <= '0;
			st.sclk_prev <= 1'b0;
			st.phase <= scir_pkg::PH_HEADER;
			st.interface_config <= scir_pkg::RST_INTERFACE_CONFIG; // [R4]
			st.power_mode_config <= scir_pkg::RST_POWER_MODE_CONFIG; // [R5]
			st.class_upper <= scir_pkg::RST_CLASS_UPPER; // [R6]
			st.sync_ctrl <= scir_pkg::RST_SYNC_REFERENCE_CONTROL;
		end else begin
			st <= next_st;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs, all straight from the state register
	assign spi_sdo = st.sdo;
	assign spi_sdo_oe = st.sdo_oe;
	assign chip_reset_request = st.reset_out;
	assign address_direction_up = st.interface_config[scir_pkg::BIT_ADDRESS_DIRECTION_UP];
	assign power_mode = st.power_mode_config[1:0];
	assign full_power_down = st.power_down;
	assign sync_reference_control = st.sync_ctrl;

endmodule

// >>> scir_regs_props.sv
/* Port checker for the register bank.
   Assumes the bind at the foot and one system clock domain. */
`timescale 1ns/1ns
module scir_regs_props (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// SPI pins
	input wire logic spi_sclk,
	input wire logic spi_cs_n,
	input wire logic spi_sdi,
	input wire logic spi_sdo,
	input wire logic spi_sdo_oe,
	// Controls
	input wire logic chip_reset_request,
	input wire logic address_direction_up,
	input wire logic [1:0] power_mode,
	input wire logic full_power_down,
	input wire logic [7:0] sync_reference_control
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	// Default register state and the soft reset pulse
	sequence s_defaults;
		address_direction_up && power_mode == 2'h0 && sync_reference_control == 8'h40;
	endsequence
	sequence s_pulse;
		chip_reset_request ##1 !chip_reset_request;
	endsequence
	pulse_single_a: assert property (chip_reset_request |-> s_pulse)
		else $error("soft reset pulse too long");
	soft_defaults_a: assert property (chip_reset_request |-> ##[0:1] s_defaults)
		else $error("no defaults after soft reset");
	boot_defaults_a: assert property ($fell(sys_rst) |-> s_defaults)
		else $error("no defaults after reset");
	power_down_a: assert property (full_power_down == (power_mode == 2'h3))
		else $error("power down flag wrong");
	write_in_frame_a: assert property (
		$changed({address_direction_up, power_mode}) |-> !$past(spi_cs_n, 4))
		else $error("control changed outside a frame");
	oe_in_frame_a: assert property ($rose(spi_sdo_oe) |-> !spi_cs_n)
		else $error("sdo driven outside a frame");
	oe_idle_a: assert property (spi_cs_n [*8] |-> !spi_sdo_oe)
		else $error("sdo still driven when idle");
endmodule
bind scir_regs scir_regs_props i_scir_regs_props (.sys_clk, .sys_rst, .spi_sclk, .spi_cs_n,
	.spi_sdi, .spi_sdo, .spi_sdo_oe, .chip_reset_request, .address_direction_up,
	.power_mode, .full_power_down, .sync_reference_control);

// >>> scir_host_model.sv
/* SPI host model, mode 0, each sclk level ten system cycles.
   Assumes the bench calls frame and drives nothing else on these pins. */
`timescale 1ns/1ns
module scir_host_model (
	// Clock
	input wire logic sys_clk,
	// SPI pins
	output logic spi_sclk,
	output logic spi_cs_n,
	output logic spi_sdi,
	input wire logic spi_sdo,
	input wire logic spi_sdo_oe
);
	// Idle pins, clock parked low between frames
	initial begin
		spi_sclk = 1'b0;
		spi_cs_n = 1'b1;
		spi_sdi = 1'b0;
	end
	// Header then n data bytes; read data gathered MSB first
	task automatic frame(input logic rd, input logic [14:0] adr, input int n,
		input logic [15:0] wd, output logic [15:0] rdat);
		logic [31:0] sh;
		sh = {rd, adr, wd};
		rdat = 16'h0000;
		@(negedge sys_clk);
		spi_cs_n = 1'b0;
		for (int i = 0; i < 16 + 8 * n; i++) begin
			spi_sdi = sh[31 - i];
			repeat (10) @(negedge sys_clk);
			// A released data line reads as the inverse of what the device holds
			if (i >= 16) rdat = {rdat[14:0], spi_sdo_oe ? spi_sdo : ~spi_sdo};
			spi_sclk = 1'b1;
			repeat (10) @(negedge sys_clk);
			spi_sclk = 1'b0;
		end
		repeat (10) @(negedge sys_clk);
		spi_cs_n = 1'b1;
		spi_sdi = ~spi_sdi; // No stale level once released
		repeat (10) @(negedge sys_clk); // Gap outlasts the soft reset time
	endtask
endmodule

// >>> test_scir_regs.sv
/* Self-checking bench for the register bank.
   Assumes the host model and the bound checker. */
`timescale 1ns/1ns
module test_scir_regs;
	localparam logic [3:0] CLS = 4'h9; // Arbitrary value
	localparam logic [15:0] FAM = 16'hC3A5; // Arbitrary value
	localparam logic [7:0] REV = 8'h07; // Arbitrary value
	localparam logic [15:0] MKR = 16'h6E21; // Arbitrary value
	logic sys_clk, sys_rst, spi_sclk, spi_cs_n, spi_sdi, spi_sdo, spi_sdo_oe;
	logic chip_reset_request, address_direction_up, full_power_down;
	logic [1:0] power_mode;
	logic [7:0] sync_reference_control;
	logic [15:0] got;
	int err_count = 0, checks_done = 0, cycles = 0, pulses = 0;
	scir_regs #(.DEVICE_CLASS(CLS), .FAMILY_CODE(FAM), .REVISION_CODE(REV),
		.MAKER_CODE(MKR)) i_scir_regs (.sys_clk, .sys_rst, .spi_sclk, .spi_cs_n,
		.spi_sdi, .spi_sdo, .spi_sdo_oe, .chip_reset_request, .address_direction_up,
		.power_mode, .full_power_down, .sync_reference_control);
	scir_host_model i_scir_host_model (.sys_clk, .spi_sclk, .spi_cs_n, .spi_sdi, .spi_sdo,
		.spi_sdo_oe);
	////////////////////////////////////////
	// Clock
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	// Cycle limit and soft reset pulse count, sampled clear of the launch edge
	always @(negedge sys_clk) begin
		cycles++;
		if (chip_reset_request === 1'b1) pulses++;
		if (cycles == 60000) begin
			err_count++;
			complete_run();
		end
	end
	////////////////////////////////////////
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic rd(input logic [14:0] a, input int n, input logic [15:0] exp);
		i_scir_host_model.frame(1'b1, a, n, 16'h0000, got);
		check(got, exp);
	endtask
	task automatic wr(input logic [14:0] a, input int n, input logic [15:0] d);
		i_scir_host_model.frame(1'b0, a, n, d, got);
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	////////////////////////////////////////
	// Test sequence
	initial begin
		sys_rst = 1'b1;
		repeat (2) @(posedge sys_clk);
		@(negedge sys_clk);
		sys_rst = 1'b0;
		repeat (5) @(negedge sys_clk);
		rd(15'h0000, 1, 16'h0030);
		rd(15'h0002, 1, 16'h0000);
		rd(15'h0080, 1, 16'h0040);
		$display("test defaults done");
		for (int k = 0; k < 2; k++) begin
			rd(15'h0003, 1, {8'h00, (k == 1) ? 4'h5 : 4'h0, CLS});
			rd(15'h0004, 2, {FAM[7:0], FAM[15:8]});
			rd(15'h0006, 1, {8'h00, REV});
			rd(15'h000C, 2, {MKR[7:0], MKR[15:8]});
			rd(15'h0007, 1, 16'h0000);
			wr(15'h0003, 1, 16'h5F00);
			wr(15'h0004, 2, ~FAM);
			wr(15'h0006, 1, 16'hFF00);
			wr(15'h000C, 2, ~MKR);
		end
		$display("test identification done");
		for (int m = 0; m < 4; m++) begin
			wr(15'h0002, 1, {6'h00, m[1:0], 8'h00});
			check({14'h0000, power_mode}, 16'(m));
			check({15'h0000, full_power_down}, {15'h0000, m == 3});
			rd(15'h0002, 1, 16'(m));
		end
		$display("test power modes done");
		wr(15'h0000, 1, 16'h0000);
		check({15'h0000, address_direction_up}, 16'h0000);
		rd(15'h0000, 1, 16'h0010);
		rd(15'h0005, 2, FAM);
		$display("test direction done");
		wr(15'h0080, 1, 16'h5A00);
		check({8'h00, sync_reference_control}, 16'h005A);
		pulses = 0;
		wr(15'h0000, 1, 16'h8000);
		check(16'(pulses), 16'h0001);
		check({15'h0000, address_direction_up}, 16'h0001);
		check({14'h0000, power_mode}, 16'h0000);
		rd(15'h0000, 1, 16'h0030);
		rd(15'h0080, 1, 16'h0040);
		check({8'h00, sync_reference_control}, 16'h0040);
		rd(15'h0003, 1, {12'h000, CLS});
		$display("test soft reset done");
		complete_run();
	end
endmodule
